// ==== core/twf_pkg.sv ====
/*
  Shared constants and types of the two-wire memory target framing block.
  Assumes a 100 MHz system clock; the serial clock is supplied by the bus controller.
*/
package twf_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WRITE_TIME_MS = 5;
  // Longest time, so integer division rounds down
  localparam int unsigned WRITE_CYCLES  = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned WR_CNT_W      = 19;

  // ==========================================================================
  // Word framing
  localparam logic [3:0]  WORD_BITS     = 4'h8;
  localparam logic [3:0]  CNT_ZERO      = 4'h0;
  localparam logic [3:0]  CNT_ONE       = 4'h1;
  localparam logic [1:0]  WORDS_ZERO    = 2'h0;
  localparam logic [1:0]  WORDS_ONE     = 2'h1;
  // Address, word address and one data word make a write sequence
  localparam logic [1:0]  WORDS_WRITE   = 2'h3;
  localparam int unsigned RW_BIT        = 0;
  localparam int unsigned MSB_BIT       = 7;

  // ==========================================================================
  // Framing states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RECV,
    ST_ACK,
    ST_SEND,
    ST_MACK,
    ST_WAIT
  } twf_state_type;

endpackage

// ==== core/twf_wr_if.sv ====
/*
  Carrier between the framing logic and the self-timed write timer.
  Assumes both ends sit on the system clock.
*/
`timescale 1ns/1ps
interface twf_wr_if;
  logic go;
  logic busy;
  modport ctl (output go, input busy);
  modport tmr (input go, output busy);
endinterface

// ==== core/twf_write_timer.sv ====
/*
  Self-timed write cycle timer: runs a fixed number of system clocks after go.
  Assumes go is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ps
module twf_write_timer
  import twf_pkg::*;
#(
  parameter int unsigned SELF_TIMED_WRITE_DURATION = WRITE_CYCLES
) (
  // System
  input  wire logic  clk,
  input  wire logic  rst,
  // Control carrier
  twf_wr_if.tmr      wr
);

  localparam logic [WR_CNT_W-1:0] LAST = WR_CNT_W'(SELF_TIMED_WRITE_DURATION - 1);
  localparam logic [WR_CNT_W-1:0] ZERO = '0;

  logic                busy_r;
  logic                busy_nxt;
  logic [WR_CNT_W-1:0] cnt_r;
  logic [WR_CNT_W-1:0] cnt_nxt;

  // ==========================================================================
  // Counter; a new go while busy is ignored
  always_comb begin
    busy_nxt = busy_r;
    cnt_nxt  = cnt_r;
    if (busy_r) begin
      if (cnt_r == LAST) begin
        busy_nxt = 1'b0;
        cnt_nxt  = ZERO;
      end else begin
        cnt_nxt = cnt_r + WR_CNT_W'(1);
      end
    end else if (wr.go) begin
      busy_nxt = 1'b1;
      cnt_nxt  = ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r  <= ZERO;
    end else begin
      busy_r <= busy_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  assign wr.busy = busy_r;

  // ==========================================================================
  // Checks
  AST_WT_LENGTH: assert property (@(posedge clk) disable iff (rst)
    $fell(busy_r) |-> $past(cnt_r) == LAST)
    else $error("write cycle ended at wrong count");
  AST_WT_START: assert property (@(posedge clk) disable iff (rst)
    wr.go && !busy_r |=> busy_r && cnt_r == ZERO)
    else $error("write cycle did not start");

endmodule

// ==== core/twf_framing.sv ====
/*
  Bus-side framing of a two-wire serial memory target: start and stop
  detection, eight-bit words, acknowledge, read shifting, standby and
  the self-timed write window.
  Assumes an external pull-up on the data wire and a controller-driven
  serial clock that may stop between frames.
*/
// Summary of operation
// - Data changes only while clock low; changes while high are start or stop.
// - Device never drives data high; it only pulls low or releases.
// - Data falling while clock high is a start; device detects it.
// - Data rising while clock high is a stop; device detects it.
// - A stop ending a read sequence puts the device in standby.
// - Every transfer is eight-bit words, one bit per clock.
// - After each received word the device pulls data low on clock nine.
// - Device is in standby right after power-up.
// - Standby only after stop and after any self-timed write finished.
// - Self-timed write finishes within five milliseconds.
// - No address acknowledge while the write cycle runs.
`timescale 1ns/1ps
module twf_framing
  import twf_pkg::*;
#(
  parameter int unsigned SELF_TIMED_WRITE_DURATION = WRITE_CYCLES
) (
  // System
  input  wire logic       clk,
  input  wire logic       rst,
  // Serial bus
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Word stream
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_first,
  input  wire logic [7:0] tx_data,
  output logic            tx_req,
  // Status
  output logic            standby,
  output logic            write_busy
);

  twf_wr_if wr ();

  // ==========================================================================
  // Link domain: capture one data bit per rising serial clock
  logic lk_bit_r;
  logic lk_tgl_r;

  // Async clear because the serial clock may not run during reset
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      lk_tgl_r <= 1'b0;
    end else begin
      lk_tgl_r <= ~lk_tgl_r;
    end
  end

  // Captured bit is stable for a whole clock period, read after the toggle
  always_ff @(posedge scl) begin
    lk_bit_r <= sda_in;
  end

  // ==========================================================================
  // Synchronisers into the system domain
  logic scl_m_r, scl_s_r, scl_d_r;
  logic sda_m_r, sda_s_r, sda_d_r;
  logic tg_m_r, tg_s_r, tg_d_r;
  logic start_det;
  logic stop_det;
  logic scl_fall;
  logic bit_evt;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
      tg_m_r  <= 1'b0;
      tg_s_r  <= 1'b0;
      tg_d_r  <= 1'b0;
    end else begin
      scl_m_r <= scl;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
      tg_m_r  <= lk_tgl_r;
      tg_s_r  <= tg_m_r;
      tg_d_r  <= tg_s_r;
    end
  end

  // Data edge while clock stays high marks a frame boundary
  assign start_det = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
  assign stop_det  = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;
  assign scl_fall  = scl_d_r && !scl_s_r;
  assign bit_evt   = tg_s_r ^ tg_d_r;

  // ==========================================================================
  // Framing state
  twf_state_type st_r, st_nxt;
  logic [3:0]    cnt_r, cnt_nxt;
  logic [7:0]    sh_r, sh_nxt;
  logic [7:0]    tx_r, tx_nxt;
  logic [7:0]    rxd_r, rxd_nxt;
  logic [1:0]    words_r, words_nxt;
  logic          oe_r, oe_nxt;
  logic          first_r, first_nxt;
  logic          rw_r, rw_nxt;
  logic          seen_r, seen_nxt;
  logic          rxv_r, rxv_nxt;
  logic          rxf_r, rxf_nxt;
  logic          txq_r, txq_nxt;
  logic          stby_r, stby_nxt;
  logic          wgo;
  logic          ack_ok;

  // Address word is refused while the write cycle is running
  assign ack_ok = !(first_r && wr.busy);

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    sh_nxt    = sh_r;
    tx_nxt    = tx_r;
    rxd_nxt   = rxd_r;
    words_nxt = words_r;
    oe_nxt    = oe_r;
    first_nxt = first_r;
    rw_nxt    = rw_r;
    seen_nxt  = seen_r;
    rxv_nxt   = 1'b0;
    rxf_nxt   = rxf_r;
    txq_nxt   = 1'b0;
    wgo       = 1'b0;
    if (start_det) begin
      // Fresh address word expected whatever was in flight
      st_nxt    = ST_RECV;
      cnt_nxt   = CNT_ZERO;
      first_nxt = 1'b1;
      words_nxt = WORDS_ZERO;
      oe_nxt    = 1'b0;
    end else if (stop_det) begin
      st_nxt  = ST_IDLE;
      cnt_nxt = CNT_ZERO;
      oe_nxt  = 1'b0;
      if (!rw_r && words_r == WORDS_WRITE) begin
        wgo = 1'b1;
      end
    end else begin
      case (st_r)
        ST_RECV: begin
          if (bit_evt && cnt_r != WORD_BITS) begin
            sh_nxt  = {sh_r[6:0], lk_bit_r};
            cnt_nxt = cnt_r + CNT_ONE;
            if (cnt_r == WORD_BITS - CNT_ONE) begin
              rxv_nxt = 1'b1;
              rxd_nxt = {sh_r[6:0], lk_bit_r};
              rxf_nxt = first_r;
            end
          end
          if (scl_fall && cnt_r == WORD_BITS) begin
            if (!ack_ok) begin
              st_nxt = ST_WAIT;
            end else begin
              oe_nxt   = 1'b1;
              st_nxt   = ST_ACK;
              seen_nxt = 1'b0;
              if (first_r) begin
                rw_nxt  = sh_r[RW_BIT];
                txq_nxt = sh_r[RW_BIT];
              end
            end
          end
        end
        ST_ACK: begin
          if (bit_evt) begin
            seen_nxt = 1'b1;
          end else if (scl_fall && seen_r) begin
            // Release only once the ninth clock has gone low again
            cnt_nxt   = CNT_ZERO;
            first_nxt = 1'b0;
            if (words_r != WORDS_WRITE) begin
              words_nxt = words_r + WORDS_ONE;
            end
            if (rw_r) begin
              st_nxt = ST_SEND;
              tx_nxt = tx_data;
              oe_nxt = ~tx_data[MSB_BIT];
            end else begin
              st_nxt = ST_RECV;
              oe_nxt = 1'b0;
            end
          end
        end
        ST_SEND: begin
          if (bit_evt) begin
            cnt_nxt = cnt_r + CNT_ONE;
          end
          if (scl_fall && cnt_r != CNT_ZERO) begin
            if (cnt_r == WORD_BITS) begin
              oe_nxt   = 1'b0;
              st_nxt   = ST_MACK;
              seen_nxt = 1'b0;
            end else begin
              tx_nxt = {tx_r[6:0], 1'b0};
              oe_nxt = ~tx_r[MSB_BIT-1];
            end
          end
        end
        ST_MACK: begin
          if (bit_evt) begin
            if (!lk_bit_r) begin
              seen_nxt = 1'b1;
              txq_nxt  = 1'b1;
            end else begin
              st_nxt = ST_WAIT;
            end
          end else if (scl_fall && seen_r) begin
            st_nxt   = ST_SEND;
            cnt_nxt  = CNT_ZERO;
            seen_nxt = 1'b0;
            tx_nxt   = tx_data;
            oe_nxt   = ~tx_data[MSB_BIT];
          end
        end
        ST_IDLE, ST_WAIT: begin
          oe_nxt = 1'b0;
        end
        default: begin
          st_nxt = ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
    // Standby waits for the write cycle, including one just requested
    stby_nxt = (st_nxt == ST_IDLE) && !wr.busy && !wgo;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r    <= ST_IDLE;
      cnt_r   <= CNT_ZERO;
      sh_r    <= '0;
      tx_r    <= '0;
      rxd_r   <= '0;
      words_r <= WORDS_ZERO;
      oe_r    <= 1'b0;
      first_r <= 1'b0;
      rw_r    <= 1'b0;
      seen_r  <= 1'b0;
      rxv_r   <= 1'b0;
      rxf_r   <= 1'b0;
      txq_r   <= 1'b0;
      stby_r  <= 1'b1;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      tx_r    <= tx_nxt;
      rxd_r   <= rxd_nxt;
      words_r <= words_nxt;
      oe_r    <= oe_nxt;
      first_r <= first_nxt;
      rw_r    <= rw_nxt;
      seen_r  <= seen_nxt;
      rxv_r   <= rxv_nxt;
      rxf_r   <= rxf_nxt;
      txq_r   <= txq_nxt;
      stby_r  <= stby_nxt;
    end
  end

  // ==========================================================================
  // Write timer and outputs
  assign wr.go = wgo;

  twf_write_timer #(
    .SELF_TIMED_WRITE_DURATION (SELF_TIMED_WRITE_DURATION)
  ) u_timer (
    .clk (clk),
    .rst (rst),
    .wr  (wr)
  );

  // Open drain: the pad value is always low, only the enable moves
  assign sda_out    = 1'b0;
  assign sda_oe     = oe_r;
  assign rx_data    = rxd_r;
  assign rx_valid   = rxv_r;
  assign rx_first   = rxf_r;
  assign tx_req     = txq_r;
  assign standby    = stby_r;
  assign write_busy = wr.busy;

  // ==========================================================================
  // Checks
  sequence s_word_in;
    st_r == ST_RECV && cnt_r == WORD_BITS && scl_fall;
  endsequence

  AST_ACK_DRIVE: assert property (@(posedge clk) disable iff (rst)
    s_word_in ##0 ack_ok |=> oe_r && st_r == ST_ACK)
    else $error("no acknowledge after eight bits");
  AST_BUSY_NOACK: assert property (@(posedge clk) disable iff (rst)
    s_word_in ##0 first_r && wr.busy && !start_det && !stop_det |=> !oe_r && st_r == ST_WAIT)
    else $error("address acknowledged during write cycle");
  AST_START_RESTART: assert property (@(posedge clk) disable iff (rst)
    start_det |=> st_r == ST_RECV && cnt_r == CNT_ZERO && first_r && !oe_r)
    else $error("start did not restart word");
  AST_STOP_RELEASE: assert property (@(posedge clk) disable iff (rst)
    stop_det |=> !oe_r && st_r == ST_IDLE)
    else $error("stop did not release data");
  AST_OE_CLOCK_LOW: assert property (@(posedge clk) disable iff (rst)
    $changed(oe_r) |-> !scl_s_r)
    else $error("data drive changed with clock high");
  AST_NEVER_HIGH: assert property (@(posedge clk) disable iff (rst)
    oe_r |-> !sda_out)
    else $error("data driven high");
  AST_WORD_EIGHT: assert property (@(posedge clk) disable iff (rst)
    rxv_r |-> cnt_r == WORD_BITS && $past(cnt_r) == WORD_BITS - CNT_ONE)
    else $error("word not eight bits");
  AST_STANDBY_GATE: assert property (@(posedge clk) disable iff (rst)
    stby_r |-> st_r == ST_IDLE && !wr.busy)
    else $error("standby while busy");
  AST_READ_STANDBY: assert property (@(posedge clk) disable iff (rst)
    stop_det && rw_r && !wr.busy |=> stby_r)
    else $error("no standby after read stop");

endmodule

// ==== verif/twf_bus_ctl.sv ====
/*
  Bus controller model: start, stop, bit, byte and free-clock tasks.
  Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
module twf_bus_ctl (
  // Serial bus
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda_wire
);
  // ==========================================================================
  // Idle bus: clock high and still between frames, data released
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // ==========================================================================
  // One clock; data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    #20 sda_pull = ~b;
    #60 scl = 1'b1;
    #40 r = sda_wire;
    #40 scl = 1'b0;
  endtask

  // Start from idle or as a repeated start
  task automatic start_cond;
    #20 sda_pull = 1'b0;
    #60 scl = 1'b1;
    #40 sda_pull = 1'b1;
    #40 scl = 1'b0;
  endtask

  // Stop ends the frame and leaves the clock high
  task automatic stop_cond;
    #20 sda_pull = 1'b1;
    #60 scl = 1'b1;
    #40 sda_pull = 1'b0;
    #40;
  endtask

  // Eight bits MSB first, ninth clock carries the acknowledge
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(a, ack);
  endtask

  // Nine clocks with no start, used as noise and as bus recovery
  task automatic clock_free(input logic [8:0] d, output logic [8:0] q);
    logic r;
    #40 scl = 1'b0;
    for (int i = 8; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    #20 sda_pull = 1'b0;
    #60 scl = 1'b1;
  endtask
endmodule

// ==== verif/tb.sv ====
/*
  Self-checking bench of the framing block against a bus controller model.
  Assumes the design package and the controller model are compiled first.
*/
`timescale 1ns/1ps
module tb;
  import twf_pkg::*;
  // Short write cycle keeps the run brief
  localparam int unsigned DUR = 400;

  logic       clk;
  logic       rst;
  logic       scl;
  logic       sda_pull;
  logic       sda_wire;
  logic       sda_out;
  logic       sda_oe;
  logic [7:0] rx_data;
  logic [7:0] tx_data;
  logic       rx_valid;
  logic       rx_first;
  logic       tx_req;
  logic       standby;
  logic       write_busy;
  int         err_count;
  int         num_checks;
  int         rxv_cnt;
  int         busy_cnt;

  // ==========================================================================
  // Clock, wire resolution and instances
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // Pull-up gives the high level; either party may pull low
  assign sda_wire = (sda_oe ? sda_out : 1'b1) & ~sda_pull;

  twf_framing #(.SELF_TIMED_WRITE_DURATION(DUR)) dut_u (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .rx_data(rx_data), .rx_valid(rx_valid), .rx_first(rx_first),
    .tx_data(tx_data), .tx_req(tx_req), .standby(standby), .write_busy(write_busy)
  );
  twf_bus_ctl ctl_u (.scl(scl), .sda_pull(sda_pull), .sda_wire(sda_wire));

  // ==========================================================================
  // Compare tasks and closing
  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(string n, logic e, logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Monitor: word count, busy length, next read byte, open-drain value
  always @(posedge clk) begin
    if (rx_valid === 1'b1) rxv_cnt++;
    if (write_busy === 1'b1) busy_cnt++;
    // Read byte source: fixed start value in reset, one step per request
    if (rst === 1'b1) tx_data <= 8'h94;
    else if (tx_req === 1'b1) tx_data <= tx_data + 8'h11;
    if (sda_oe === 1'b1) chk1("sda_out", 1'b0, sda_out);
  end

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    chk1("standby", 1'b1, standby);
    chk1("sda_oe", 1'b0, sda_oe);
    chk1("write_busy", 1'b0, write_busy);
    $display("t_reset done");
  endtask

  // Byte write, address probe while busy, standby after the cycle
  task automatic t_write;
    logic [7:0] q;
    logic       a;
    busy_cnt = 0;
    ctl_u.start_cond();
    ctl_u.byte_io(8'ha0, 1'b1, q, a);
    chk1("ack_addr", 1'b0, a);
    chk8("rx_addr", 8'ha0, rx_data);
    chk1("rx_first", 1'b1, rx_first);
    ctl_u.byte_io(8'h5c, 1'b1, q, a);
    chk1("ack_word", 1'b0, a);
    chk8("rx_word", 8'h5c, rx_data);
    chk1("rx_first2", 1'b0, rx_first);
    ctl_u.byte_io(8'h3e, 1'b1, q, a);
    chk1("ack_data", 1'b0, a);
    ctl_u.stop_cond();
    repeat (8) @(posedge clk);
    chk1("busy", 1'b1, write_busy);
    chk1("standby_busy", 1'b0, standby);
    ctl_u.start_cond();
    ctl_u.byte_io(8'ha0, 1'b1, q, a);
    chk1("nack_busy", 1'b1, a);
    ctl_u.stop_cond();
    repeat (4) @(posedge clk);
    chk1("standby_stop", 1'b0, standby);
    for (int i = 0; i < 1000 && write_busy !== 1'b0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk1("standby_end", 1'b1, standby);
    chk1("busy_len", 1'b1, busy_cnt >= DUR - 1 && busy_cnt <= DUR);
    $display("t_write done");
  endtask

  // Two read bytes, master ack then no ack, stop gives standby
  task automatic t_read;
    logic [7:0] q;
    logic       a;
    ctl_u.start_cond();
    ctl_u.byte_io(8'ha1, 1'b1, q, a);
    chk1("ack_rd", 1'b0, a);
    ctl_u.byte_io(8'hff, 1'b0, q, a);
    chk8("rd0", 8'ha5, q);
    ctl_u.byte_io(8'hff, 1'b1, q, a);
    chk8("rd1", 8'hb6, q);
    ctl_u.stop_cond();
    repeat (8) @(posedge clk);
    chk1("standby_rd", 1'b1, standby);
    $display("t_read done");
  endtask

  // Start and stop in mid-word drop the partial word
  task automatic t_restart;
    logic [7:0] q;
    logic       a;
    logic       r;
    int         n;
    n = rxv_cnt;
    ctl_u.start_cond();
    for (int i = 0; i < 4; i++) ctl_u.bit_io(1'b1, r);
    ctl_u.start_cond();
    ctl_u.byte_io(8'h5a, 1'b1, q, a);
    chk1("ack_re", 1'b0, a);
    chk8("rx_re", 8'h5a, rx_data);
    chk1("first_re", 1'b1, rx_first);
    chk8("cnt_re", 8'(n + 1), 8'(rxv_cnt));
    for (int i = 0; i < 3; i++) ctl_u.bit_io(1'b1, r);
    ctl_u.stop_cond();
    repeat (8) @(posedge clk);
    chk8("cnt_stop", 8'(n + 1), 8'(rxv_cnt));
    chk1("oe_stop", 1'b0, sda_oe);
    chk1("standby_p", 1'b1, standby);
    $display("t_restart done");
  endtask

  // Clocks with no start are ignored; recovery then a fresh start
  task automatic t_recover;
    logic [8:0] v;
    logic [7:0] q;
    logic       a;
    int         n;
    n = rxv_cnt;
    ctl_u.clock_free(9'h000, v);
    repeat (8) @(posedge clk);
    chk8("cnt_nostart", 8'(n), 8'(rxv_cnt));
    chk1("oe_nostart", 1'b0, sda_oe);
    ctl_u.clock_free(9'h1ff, v);
    chk1("sda_free", 1'b1, &v);
    // Abandon a read right after its address acknowledge, then clock the target free
    ctl_u.start_cond();
    ctl_u.byte_io(8'ha1, 1'b1, q, a);
    chk1("ack_cut", 1'b0, a);
    ctl_u.clock_free(9'h1ff, v);
    // Byte source has stepped three times from its reset value by now
    chk8("rd_cut", 8'hc7, v[8:1]);
    chk1("sda_cut", 1'b1, v[0]);
    ctl_u.start_cond();
    ctl_u.byte_io(8'ha0, 1'b1, q, a);
    chk1("ack_rec", 1'b0, a);
    ctl_u.stop_cond();
    $display("t_recover done");
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    // Non-blocking, so the link toggle's async clear sees a rising edge at time zero
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_write();
    t_read();
    t_restart();
    t_recover();
    stop_test();
  end

  // Whole run needs about 25 us; a hang is cut well after that
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
endmodule
